// ---- bench/host_cmd_model.sv ----
`timescale 1ns/1ps
`include "row_repair_params.svh"
// controller side of the command bus: one command per issue call
module host_cmd_model
   import row_repair_pkg::*;
#(
   parameter int BANKS       = 8,
   parameter int ROW_BITS    = 17,
   parameter int PROGRAM_CYC = 20,
   parameter int SETTLE_CYC  = 5
)
(
   // clock
   input  wire logic                     i_core_clk,
   // command bus toward the device
   output logic                          o_cmd_valid,
   output dram_cmd_t                     o_cmd,
   output logic [7:0]                    o_mr_addr,
   output logic [7:0]                    o_mr_data,
   output logic [$clog2(BANKS)-1:0]      o_bank,
   output logic [ROW_BITS-1:0]           o_row
);
   localparam int EXIT_CYC = `REPAIR_EXIT_CYC;
   localparam logic [7:0] EN_ON = 8'h01 << `REPAIR_ENABLE_BIT;

   // quiet bus at time zero
   initial
   begin
      o_cmd_valid = 1'b0;
      o_cmd = CMD_NOP;
      o_mr_addr = 8'h00;
      o_mr_data = 8'h00;
      o_bank = '0;
      o_row = '0;
   end

   // ends just after an edge so the caller never samples at the edge
   task automatic idle(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask : idle

   // released address, data and row lines show the inverse so stale values never look valid; bank keeps its value
   task automatic issue(input dram_cmd_t c, input logic [7:0] a,
                        input logic [7:0] d,
                        input logic [$clog2(BANKS)-1:0] b,
                        input logic [ROW_BITS-1:0] r);
      @(posedge i_core_clk);
      #1;
      o_cmd_valid = 1'b1;
      o_cmd = c;
      o_mr_addr = a;
      o_mr_data = d;
      o_bank = b;
      o_row = r;
      @(posedge i_core_clk);
      #1;
      o_cmd_valid = 1'b0;
      o_cmd = CMD_NOP;
      o_mr_addr = ~a;
      o_mr_data = ~d;
      o_row = ~r;
   endtask : issue

   // bank select doubles as the fuse lookup index, so it is a level
   task automatic look(input logic [$clog2(BANKS)-1:0] b);
      @(posedge i_core_clk);
      #1;
      o_bank = b;
      idle(2);
      #1;
   endtask : look

   // one whole sequence; the caller alone decides to start it
   task automatic repair(input logic [$clog2(BANKS)-1:0] b,
                         input logic [ROW_BITS-1:0] r);
      issue(CMD_MRW, `REPAIR_ENABLE_REG_ADDR, EN_ON, b, r);
      idle(2);
      issue(CMD_ACT, 8'h00, 8'h00, b, r);
      idle(PROGRAM_CYC + 2);
      issue(CMD_PRE, 8'h00, 8'h00, b, r);
      idle(EXIT_CYC + 2);
      issue(CMD_MRW, `REPAIR_ENABLE_REG_ADDR, 8'h00, b, r);
      idle(SETTLE_CYC + 4);
   endtask : repair
endmodule : host_cmd_model

// ---- bench/row_spare_repair_test.sv ----
`timescale 1ns/1ps
`include "row_repair_params.svh"
module row_spare_repair_test;
   import row_repair_pkg::*;
   localparam logic [7:0] RES_VAL = 8'ha5;
   logic            clk = 1'b0;
   logic            rst = 1'b1;
   logic            ce = 1'b1;
   logic [7:0]      bank_open = 8'h00;
   logic            cmd_valid;
   dram_cmd_t       cmd;
   logic [7:0]      mr_addr;
   logic [7:0]      mr_data;
   logic [2:0]      bank;
   logic [16:0]     row;
   logic            mrr_valid;
   logic [7:0]      mrr_data;
   logic            rmode;
   logic            rinh;
   logic            busy;
   logic            need_rst;
   logic            viol;
   logic            used;
   logic [16:0]     mrow;
   int              fails = 0;
   int              tests_run = 0;
   logic [7:0]      row_addr [4] = '{8'h19, 8'h04, 8'h00, 8'h33};
   logic [7:0]      row_want [4] = '{RES_VAL, `REPAIR_ENABLE_RESET, 8'h00,
                                     8'h00};

   always #5 clk = ~clk;

   row_spare_repair #(.PROGRAM_CYC(20), .SETTLE_CYC(5),
                      .RESOURCE_VALUE(RES_VAL)) i_dut (
      .i_core_clk(clk), .i_sys_rst(rst), .i_ce(ce),
      .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_mr_addr(mr_addr),
      .i_mr_data(mr_data), .i_bank(bank), .i_row(row),
      .i_bank_open(bank_open), .o_mrr_valid(mrr_valid),
      .o_mrr_data(mrr_data), .o_repair_mode(rmode),
      .o_refresh_inhibit(rinh), .o_busy(busy), .o_need_reset(need_rst),
      .o_violation(viol), .o_map_used(used), .o_map_row(mrow));

   host_cmd_model #(.PROGRAM_CYC(20), .SETTLE_CYC(5)) i_host (
      .i_core_clk(clk), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
      .o_mr_addr(mr_addr), .o_mr_data(mr_data), .o_bank(bank),
      .o_row(row));

   task automatic check(input logic [31:0] seen, input logic [31:0] want,
                        input string msg);
      tests_run++;
      if (seen !== want)
      begin
         fails++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic end_of_test;
      $display("tests_run %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test

   // reset is held ten cycles, then released just after an edge
   task automatic do_reset;
      @(posedge clk);
      #1;
      rst = 1'b1;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
   endtask : do_reset

   // answer may land in the edge's own step or one later: bounded wait
   task automatic mrr(input logic [7:0] a, input logic [7:0] want);
      int n;
      n = 0;
      i_host.issue(CMD_MRR, a, 8'h00, bank, 17'h0);
      while (mrr_valid !== 1'b1 && n < 3)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check(mrr_valid, 1'b1, "read answer");
      check(mrr_data, want, "read data");
   endtask : mrr

   task automatic status(input logic [4:0] want, input string msg);
      check({rmode, rinh, busy, need_rst, viol}, want, msg);
   endtask : status

   initial
   begin
      #100us;
      fails++;
      end_of_test();
   end

   initial
   begin
      do_reset();
      status(5'h00, "reset status");
      check(mrr_valid, 1'b0, "reset answer flag");
      for (int i = 0; i < 4; i++)
      begin
         mrr(row_addr[i], row_want[i]);
      end
      $display("test reads done");
      fork
         i_host.repair(3'h3, 17'h1abcd);
         begin
            repeat (5) @(posedge clk);
            #2;
            status(5'h1c, "repair mode status");
         end
      join
      status(5'h02, "done status");
      i_host.look(3'h3);
      check({used, mrow}, {1'b1, 17'h1abcd}, "spare row");
      i_host.look(3'h5);
      check(used, 1'b0, "other bank untouched");
      $display("test repair done");
      do_reset();
      i_host.look(3'h3);
      check({used, mrow}, {1'b1, 17'h1abcd}, "fuse kept");
      i_host.repair(3'h3, 17'h00123);
      i_host.repair(3'h5, 17'h00077);
      i_host.look(3'h3);
      check(mrow, 17'h1abcd, "second fuse refused");
      i_host.look(3'h5);
      check({used, mrow}, {1'b1, 17'h00077}, "next bank");
      $display("test repeat done");
      do_reset();
      bank_open = 8'h04;
      i_host.issue(CMD_MRW, 8'h04, 8'h10, 3'h0, 17'h0);
      i_host.idle(2);
      status(5'h01, "open bank entry");
      bank_open = 8'h00;
      do_reset();
      status(5'h00, "violation cleared");
      i_host.issue(CMD_MRW, 8'h04, 8'h10, 3'h1, 17'h0);
      i_host.idle(2);
      i_host.issue(CMD_ACT, 8'h00, 8'h00, 3'h1, 17'h00aaa);
      i_host.idle(3);
      // enable low: the command is not taken, nothing moves
      ce = 1'b0;
      i_host.issue(CMD_REF, 8'h00, 8'h00, 3'h1, 17'h0);
      i_host.idle(2);
      check(viol, 1'b0, "frozen by enable");
      check(busy, 1'b1, "frozen busy");
      ce = 1'b1;
      i_host.issue(CMD_REF, 8'h00, 8'h00, 3'h1, 17'h0);
      i_host.idle(2);
      check(viol, 1'b1, "command while fusing");
      check(rinh, 1'b1, "refresh held off");
      $display("test refusals done");
      end_of_test();
   end
endmodule : row_spare_repair_test

// ---- design/row_repair_params.svh ----
`ifndef ROW_REPAIR_PARAMS_SVH
`define ROW_REPAIR_PARAMS_SVH
// mode register addresses (8-bit mode register address space)
`define REPAIR_RESOURCE_REG_ADDR 8'h19
`define REPAIR_ENABLE_REG_ADDR   8'h04
// field position of the repair enable bit in the enable register
`define REPAIR_ENABLE_BIT        4
// reset value of the enable register
`define REPAIR_ENABLE_RESET      8'h00
// timing figures in their printed units
`define REPAIR_PROGRAM_TIME_MS   1000
`define REPAIR_EXIT_GAP_NS       15
`define REPAIR_SETTLE_TIME_US    50
`define CLK_PERIOD_NS            10
// cycle counts: least times round up
`define REPAIR_PROGRAM_CYC  ((`REPAIR_PROGRAM_TIME_MS*1000000+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define REPAIR_EXIT_CYC     ((`REPAIR_EXIT_GAP_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define REPAIR_SETTLE_CYC   ((`REPAIR_SETTLE_TIME_US*1000+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`endif

// ---- design/row_repair_pkg.sv ----
package row_repair_pkg;
   // command codes as decoded from the command bus
   typedef enum logic [2:0]
   {
      CMD_NOP,
      CMD_MRW,
      CMD_MRR,
      CMD_ACT,
      CMD_PRE,
      CMD_REF,
      CMD_OTHER
   } dram_cmd_t;
   // repair sequencer states
   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_ARMED,
      ST_PROGRAM,
      ST_EXIT_GAP,
      ST_WAIT_EXIT,
      ST_SETTLE,
      ST_NEED_RESET
   } repair_state_t;
endpackage : row_repair_pkg

// ---- design/row_spare_repair.sv ----
`timescale 1ns/1ps
`include "row_repair_params.svh"
// What this block does
// - resource register readable as eight-bit field
// - one spare row per bank
// - programmed fuse never reverts
// - settle time before any command
// - one activate repairs one row
// - no refresh while in repair mode
module row_spare_repair
   import row_repair_pkg::*;
#(
   parameter int BANKS        = 8,
   parameter int ROW_BITS     = 17,
   parameter int PROGRAM_CYC  = `REPAIR_PROGRAM_CYC,
   parameter int SETTLE_CYC   = `REPAIR_SETTLE_CYC,
   parameter logic [7:0] RESOURCE_VALUE = 8'hff
)
(
   // clock, reset, enable
   input  wire logic                     i_core_clk,
   input  wire logic                     i_sys_rst,
   input  wire logic                     i_ce,
   // decoded command bus
   input  wire logic                     i_cmd_valid,
   input  wire dram_cmd_t                i_cmd,
   input  wire logic [7:0]               i_mr_addr,
   input  wire logic [7:0]               i_mr_data,
   input  wire logic [$clog2(BANKS)-1:0] i_bank,
   input  wire logic [ROW_BITS-1:0]      i_row,
   input  wire logic [BANKS-1:0]         i_bank_open,
   // mode register read answer
   output logic                          o_mrr_valid,
   output logic [7:0]                    o_mrr_data,
   // status
   output logic                          o_repair_mode,
   output logic                          o_refresh_inhibit,
   output logic                          o_busy,
   output logic                          o_need_reset,
   output logic                          o_violation,
   // repaired row map lookup
   output logic                          o_map_used,
   output logic [ROW_BITS-1:0]           o_map_row
);
   localparam int CNT_W = $clog2(PROGRAM_CYC + 2);
   localparam int EXIT_CYC = `REPAIR_EXIT_CYC;

   // elaboration check: every wait must fit the one shared down-counter
   if (BANKS < 2 || ROW_BITS < 1 || PROGRAM_CYC < 1 || SETTLE_CYC < 1
       || SETTLE_CYC > PROGRAM_CYC || EXIT_CYC > PROGRAM_CYC)
   begin : g_bad_params
      $error("row_spare_repair: unsupported parameters");
   end

   typedef struct packed
   {
      repair_state_t               state;
      logic [CNT_W-1:0]            cnt;
      logic [7:0]                  enable_reg;
      logic                        mrr_valid;
      logic [7:0]                  mrr_data;
      logic                        violation;
      logic                        prog;
      logic [$clog2(BANKS)-1:0]    prog_bank;
      logic [ROW_BITS-1:0]         prog_row;
      logic                        busy;
      logic                        need_reset;
   } state_t;

   state_t cur_ff;
   state_t nxt_cur;

   logic fuse_used;
   logic [ROW_BITS-1:0] fuse_row;

   // true when a command is a write to the given mode register
   function automatic logic is_mrw(input dram_cmd_t c,
                                   input logic [7:0] a,
                                   input logic [7:0] want);
      is_mrw = (c == CMD_MRW) && (a == want);
   endfunction : is_mrw

   // next-state logic
   always_comb
   begin
      nxt_cur           = cur_ff;
      nxt_cur.mrr_valid = 1'b0;
      nxt_cur.prog      = 1'b0;
      if (cur_ff.cnt != '0)
         nxt_cur.cnt = cur_ff.cnt - CNT_W'(1);
      // mode register reads answer the resource field, the enable register, or zero for other addresses
      if (i_cmd_valid && i_cmd == CMD_MRR)
      begin
         nxt_cur.mrr_valid = 1'b1;
         if (i_mr_addr == `REPAIR_RESOURCE_REG_ADDR)
            nxt_cur.mrr_data = RESOURCE_VALUE;
         else if (i_mr_addr == `REPAIR_ENABLE_REG_ADDR)
            nxt_cur.mrr_data = cur_ff.enable_reg;
         else
            nxt_cur.mrr_data = 8'h00;
      end
      unique case (cur_ff.state)
         // a finished sequence may be rerun for the next failed row
         ST_IDLE, ST_NEED_RESET:
         begin
            if (i_cmd_valid && is_mrw(i_cmd, i_mr_addr,
                                      `REPAIR_ENABLE_REG_ADDR))
            begin
               // entry with an open bank is refused: flag, mode stays off
               if (i_mr_data[`REPAIR_ENABLE_BIT] && i_bank_open != '0)
                  nxt_cur.violation = 1'b1;
               else
               begin
                  nxt_cur.enable_reg = i_mr_data;
                  if (i_mr_data[`REPAIR_ENABLE_BIT])
                     nxt_cur.state = ST_ARMED;
               end
            end
         end
         ST_ARMED:
         begin
            if (i_cmd_valid && i_cmd == CMD_ACT)
            begin
               // one activate programs exactly one row
               nxt_cur.state     = ST_PROGRAM;
               nxt_cur.cnt       = CNT_W'(PROGRAM_CYC);
               nxt_cur.prog      = 1'b1;
               nxt_cur.prog_bank = i_bank;
               nxt_cur.prog_row  = i_row;
            end
         end
         ST_PROGRAM:
         begin
            if (i_cmd_valid && i_cmd != CMD_NOP)
            begin
               // early precharge or any other command is a violation
               if (cur_ff.cnt != '0 || i_cmd != CMD_PRE)
                  nxt_cur.violation = 1'b1;
               if (cur_ff.cnt == '0 && i_cmd == CMD_PRE)
               begin
                  nxt_cur.state = ST_EXIT_GAP;
                  nxt_cur.cnt   = CNT_W'(EXIT_CYC);
               end
            end
         end
         ST_EXIT_GAP:
         begin
            if (i_cmd_valid && i_cmd != CMD_NOP)
               nxt_cur.violation = 1'b1;
            if (cur_ff.cnt == '0)
               nxt_cur.state = ST_WAIT_EXIT;
         end
         ST_WAIT_EXIT:
         begin
            if (i_cmd_valid && is_mrw(i_cmd, i_mr_addr,
                                      `REPAIR_ENABLE_REG_ADDR)
                && !i_mr_data[`REPAIR_ENABLE_BIT])
            begin
               nxt_cur.enable_reg = i_mr_data;
               nxt_cur.state      = ST_SETTLE;
               nxt_cur.cnt        = CNT_W'(SETTLE_CYC);
            end
         end
         ST_SETTLE:
         begin
            if (i_cmd_valid && i_cmd != CMD_NOP)
               nxt_cur.violation = 1'b1;
            if (cur_ff.cnt == '0)
               nxt_cur.state = ST_NEED_RESET;
         end
         default:
            nxt_cur.state = ST_IDLE;
      endcase
      // status levels follow the next state so they leave from flops
      nxt_cur.busy       = (nxt_cur.state != ST_IDLE)
                           && (nxt_cur.state != ST_NEED_RESET);
      nxt_cur.need_reset = (nxt_cur.state == ST_NEED_RESET);
   end

   // state register; reset returns to idle but keeps fuses
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         cur_ff            <= '0;
         cur_ff.state      <= ST_IDLE;
         cur_ff.enable_reg <= `REPAIR_ENABLE_RESET;
      end
      else if (i_ce)
         cur_ff <= nxt_cur;
   end

   // per-bank fuse store; second program to a bank is ignored
   spare_fuse_mem #(
      .BANKS    (BANKS),
      .ROW_BITS (ROW_BITS)
   ) u_fuse (
      .i_core_clk  (i_core_clk),
      .i_sys_rst   (i_sys_rst),
      .i_ce        (i_ce),
      .i_prog      (cur_ff.prog),
      .i_prog_bank (cur_ff.prog_bank),
      .i_prog_row  (cur_ff.prog_row),
      .i_rd_bank   (i_bank),
      .o_rd_used   (fuse_used),
      .o_rd_row    (fuse_row)
   );

   // outputs straight from flip-flops
   assign o_mrr_valid       = cur_ff.mrr_valid;
   assign o_mrr_data        = cur_ff.mrr_data;
   assign o_repair_mode     = cur_ff.enable_reg[`REPAIR_ENABLE_BIT];
   // refresh stays off for the whole repair mode
   assign o_refresh_inhibit = cur_ff.enable_reg[`REPAIR_ENABLE_BIT];
   assign o_busy            = cur_ff.busy;
   assign o_need_reset      = cur_ff.need_reset;
   assign o_violation       = cur_ff.violation;
   assign o_map_used        = fuse_used;
   assign o_map_row         = fuse_row;

   // programming lasts its full count before leaving
   prog_hold_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (cur_ff.state == ST_PROGRAM && cur_ff.cnt != '0)
      |=> cur_ff.state == ST_PROGRAM)
      else $error("left programming early");

   mrr_resource_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (i_ce && i_cmd_valid && i_cmd == CMD_MRR
       && i_mr_addr == `REPAIR_RESOURCE_REG_ADDR)
      |=> o_mrr_valid && o_mrr_data == RESOURCE_VALUE)
      else $error("resource read wrong");

   refresh_off_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (cur_ff.state == ST_PROGRAM) |-> o_refresh_inhibit)
      else $error("refresh allowed in repair");

   open_bank_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (i_ce && cur_ff.state == ST_IDLE && i_bank_open != '0)
      |=> cur_ff.state == ST_IDLE)
      else $error("entered with open bank");

   one_prog_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (cur_ff.prog && i_ce) |=> !cur_ff.prog)
      else $error("double program pulse");
endmodule : row_spare_repair

// ---- design/spare_fuse_mem.sv ----
`timescale 1ns/1ps
// one fuse word per bank: write-once, read data registered
module spare_fuse_mem
#(
   parameter int BANKS    = 8,
   parameter int ROW_BITS = 17
)
(
   // clock and control
   input  wire logic                     i_core_clk,
   input  wire logic                     i_sys_rst,
   input  wire logic                     i_ce,
   // program port
   input  wire logic                     i_prog,
   input  wire logic [$clog2(BANKS)-1:0] i_prog_bank,
   input  wire logic [ROW_BITS-1:0]      i_prog_row,
   // read port
   input  wire logic [$clog2(BANKS)-1:0] i_rd_bank,
   output logic                          o_rd_used,
   output logic [ROW_BITS-1:0]           o_rd_row
);
   // elaboration check: the bank index must be at least one bit wide
   if (BANKS < 2 || ROW_BITS < 1)
   begin : g_bad_params
      $error("spare_fuse_mem: unsupported parameters");
   end

   logic [ROW_BITS-1:0] row_mem [BANKS];
   // fuses power up unblown; no reset ever clears them
   logic [BANKS-1:0]    used_ff = '0;

   // fuses are not cleared by reset: a blown fuse stays blown
   always_ff @(posedge i_core_clk)
   begin
      if (i_ce && i_prog && !used_ff[i_prog_bank])
      begin
         row_mem[i_prog_bank] <= i_prog_row;
         used_ff[i_prog_bank] <= 1'b1;
      end
   end

   // a used flag may rise but never fall again
   fuse_keep_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (($past(used_ff) & ~used_ff) == '0))
      else $error("fuse reverted");

   // registered read port
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         o_rd_used <= 1'b0;
         o_rd_row  <= '0;
      end
      else if (i_ce)
      begin
         o_rd_used <= used_ff[i_rd_bank];
         o_rd_row  <= row_mem[i_rd_bank];
      end
   end
endmodule : spare_fuse_mem
